// >>> bench/mbsi_bus_master.sv
// Bus master model that issues the address strobe and read or write strobes
`timescale 1ns/1ps
module mbsi_bus_master (
    input  wire logic       clk_i,   // Bus clock
    output logic            als_o,   // Address latch strobe
    output logic            ots_o,   // Output timing strobe
    output logic      [7:0] addr_o,  // Multiplexed address bus
    output logic            rd_n_o,  // Memory read, active low
    output logic            wr_n_o,  // Memory write, active low
    output logic      [7:0] data_o,  // Bus data toward the board
    output logic            probe_o  // Transfer settled for sampling
);
    // Idle bus at time zero
    initial begin
        {als_o, ots_o, rd_n_o, wr_n_o, probe_o} = 5'h06;
        addr_o = 8'h00;
        data_o = 8'h5A;
    end

    // high byte before strobe end, strobe held
    task automatic access(input logic [7:0] hi, input logic rd, input logic use_als,
                          input logic [7:0] wd);
        @(negedge clk_i);
        als_o  = use_als;
        addr_o = hi;
        @(negedge clk_i);
        als_o  = 1'b0;
        ots_o  = 1'b1;
        addr_o = 8'($urandom);
        rd_n_o = !rd;
        wr_n_o = rd;
        if (!rd) data_o = wd;
        @(negedge clk_i);
        ots_o   = 1'b0;
        probe_o = 1'b1;
        @(negedge clk_i);
        probe_o = 1'b0;
        {rd_n_o, wr_n_o} = 2'h3;
        // Released bus shows the inverse so stale data cannot pass
        data_o = ~data_o;
        // Slow master now and then
        repeat ($urandom_range(1, 0)) @(negedge clk_i);
    endtask : access
endmodule : mbsi_bus_master

// >>> bench/mbsi_select_tb_top.sv
// Self-checking bench for the select and inhibit logic
`timescale 1ns/1ps
module mbsi_select_tb_top;
    import mbsi_pkg::*;
    typedef struct packed {
        logic        sel;
        logic        rd;
        logic [15:0] cs_n;
        logic [7:0]  dat;
    } mbsi_note_type;
    logic          clk, srst, als, ots, rd_n, wr_n, probe, bank_f, bank_e, seg_e, seg_f;
    logic          oe, buf_in, mem_oe_n, mem_we_n, memory_select;
    logic [1:0]    hole;
    logic [3:0]    mode;
    logic [7:0]    addr, dbus, rdat, dout, wdat;
    logic [15:0]   cs_n;
    mbsi_note_type notes[$];
    mbsi_note_type cur;
    int            n_errors = 0;
    int            n_checks = 0;

    mbsi_select dut (.CLK_I(clk), .SRST_I(srst), .ALS_I(als), .OTS_I(ots), .ADDR_I(addr),
        .MEM_RD_N_I(rd_n), .MEM_WR_N_I(wr_n), .MODE_I(mode), .BANK_F_LINK_I(bank_f),
        .BANK_E_LINK_I(bank_e), .SEG_E_LINK_I(seg_e), .SEG_F_LINK_I(seg_f),
        .HOLE_SEL_I(hole), .DATA_I(dbus), .DATA_O(dout), .DATA_OE_O(oe),
        .BUF_IN_EN_O(buf_in), .CS_N_O(cs_n), .MEM_OE_N_O(mem_oe_n), .MEM_WE_N_O(mem_we_n),
        .MEM_SEL_O(memory_select), .WR_DATA_O(wdat), .RD_DATA_I(rdat));
    mbsi_bus_master u_master (.clk_i(clk), .als_o(als), .ots_o(ots), .addr_o(addr),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(dbus), .probe_o(probe));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Expected answer from mode, links and the latched high byte
    function automatic mbsi_note_type expect_of(input logic [7:0] hi, input logic rd,
                                                input logic [7:0] wd);
        mbsi_note_type n;
        logic [3:0]    m;
        logic [3:0]    nib;
        logic          hit;
        m = (mode == 4'hF) ? 4'h0 : mode;
        if (m inside {4'h4, 4'h5, 4'h6}) begin
            nib = hi[7:4];
            hit = !(m == 4'h6 && nib == 4'hF);
            if ((nib == 4'hF && !bank_f) || (nib == 4'hE && !bank_e)) hit = 1'b0;
            if (((nib == 4'hE && seg_e) || (nib == 4'hF && seg_f))
                && hi[3:2] == hole) hit = 1'b0;
        end else begin
            nib = hi[6:3];
            hit = hi[7] == (m inside {4'h2, 4'h3, 4'h9, 4'hA, 4'hD, 4'hE});
        end
        n.sel  = hit;
        n.rd   = rd;
        n.cs_n = ~(16'(hit) << nib);
        n.dat  = rd ? rdat : wd;
        return n;
    endfunction : expect_of

    task automatic go(input logic [7:0] hi, input logic rd, input logic use_als);
        logic [7:0] wd;
        wd   = 8'($urandom);
        rdat = 8'($urandom);
        notes.push_back(expect_of(hi, rd, wd));
        u_master.access(hi, rd, use_als, wd);
    endtask : go

    // Oldest note is compared when the master marks a settled transfer
    always @(posedge clk) begin
        if (probe) begin
            cur = notes.pop_front();
            chk(16'(memory_select), 16'(cur.sel));
            chk(cs_n, cur.cs_n);
            chk(16'({oe, buf_in}), 16'({cur.sel && cur.rd, cur.sel && !cur.rd}));
            chk(16'({mem_oe_n, mem_we_n}), 16'({!(cur.sel && cur.rd), !(cur.sel && !cur.rd)}));
            if (cur.sel) chk(16'(cur.rd ? dout : wdat), 16'(cur.dat));
        end
        // Memory output enable stays off while the timing strobe is high
        if (ots) chk(16'(mem_oe_n), 16'h0001);
    end

    initial begin
        void'($urandom(32'hA934));
        srst = 1'b1;
        mode = 4'h0;
        {bank_f, bank_e, seg_e, seg_f, hole} = 6'h30;
        rdat = 8'h00;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        go(8'h7F, 1'b1, 1'b1);
        go(8'h80, 1'b1, 1'b1);
        go(8'h00, 1'b0, 1'b1);
        for (int m = 0; m < 16; m++) begin
            mode = 4'(m);
            for (int k = 0; k < 8; k++) go(8'($urandom), k[0], 1'b1);
        end
        mode = 4'h6;
        go(8'hF0, 1'b1, 1'b1);
        go(8'hEC, 1'b0, 1'b1);
        // random links, banks E and F, all large-part modes
        for (int k = 0; k < 64; k++) begin
            mode = 4'(4 + k % 3);
            {bank_f, bank_e, seg_e, seg_f, hole} = 6'($urandom);
            go({3'h7, 5'($urandom)}, k[0], 1'b1);
        end
        mode = 4'h0;
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        go(8'h00, 1'b1, 1'b0);
        repeat (3) @(negedge clk);
        stop_test();
    end

    // About 200 transfers of at most 5 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule : mbsi_select_tb_top

// >>> pkg/mbsi_pkg.sv
// Package of constants and types for the memory board select and inhibit logic
// How it works
// - Buffers enable only on active select gate
// - Open bank F link ignores bank F
// - Open bank E link ignores bank E
// - Holes use decoder, bank links stay closed
// - Hole decoder marks exactly one kilobyte segment
// - Segment link chooses bank E or F
// - Default is small ROM in low half
// - Fifteen configurations of type, placement, inhibit
// - Inhibited region: no buffers, no chip selects
// - High address byte latched at strobe end
// - Bits 7:6 and 5:4, or 6:5 and 4:3 on small parts, form sixteen selects
// - Drive bus on read, else accept data
package mbsi_pkg;

    // ************************************************************
    // Configuration modes
    // ************************************************************
    typedef enum logic [3:0] {
        MBSI_ROM2K_LOW      = 4'h0,
        MBSI_ROM2K_LOW_INH  = 4'h1,
        MBSI_ROM2K_HIGH     = 4'h2,
        MBSI_ROM2K_HIGH_INH = 4'h3,
        MBSI_ROM4K_FULL     = 4'h4,
        MBSI_ROM4K_FULL_INH = 4'h5,
        MBSI_ROM4K_NO_F     = 4'h6,
        MBSI_RAM_LOW        = 4'h7,
        MBSI_RAM_LOW_INH    = 4'h8,
        MBSI_RAM_HIGH       = 4'h9,
        MBSI_RAM_HIGH_INH   = 4'hA,
        MBSI_MIX_LOW        = 4'hB,
        MBSI_MIX_LOW_INH    = 4'hC,
        MBSI_MIX_HIGH       = 4'hD,
        MBSI_MIX_HIGH_INH   = 4'hE
    } mbsi_mode_type;

    // ************************************************************
    // Reset values and field positions
    // ************************************************************
    localparam logic [3:0] MBSI_MODE_RESET  = 4'h0;
    localparam logic [7:0] MBSI_HIGH_RESET  = 8'h00;
    localparam logic [3:0] MBSI_BANK_E      = 4'hE;
    localparam logic [3:0] MBSI_BANK_F      = 4'hF;
    localparam int         MBSI_BLOCK_HI    = 7;
    localparam int         MBSI_BLOCK_LO    = 6;
    localparam int         MBSI_SUB_HI      = 5;
    localparam int         MBSI_SUB_LO      = 4;
    localparam int         MBSI_SEG_HI      = 3;
    localparam int         MBSI_SEG_LO      = 2;
    localparam logic [3:0] MBSI_NUM_MODES   = 4'hF;

endpackage : mbsi_pkg

// >>> verilog/mbsi_addr_latch.sv
// High address byte latch taken at the trailing edge of the address strobe
`timescale 1ns/1ps
module mbsi_addr_latch
    import mbsi_pkg::*;
(
    input  wire logic       clk_i,     // System clock
    input  wire logic       srst_i,    // Synchronous reset
    input  wire logic       strobe_i,  // Address latch strobe
    input  wire logic [7:0] addr_i,    // Multiplexed address bus
    output logic      [7:0] high_o     // Latched high byte
);

    logic       strobe_ff;
    logic       nxt_strobe;
    logic [7:0] high_ff;
    logic [7:0] nxt_high;

    // Capture while strobe high so the byte before the fall is kept
    always_comb begin
        nxt_strobe = strobe_i;
        nxt_high   = high_ff;
        if (strobe_i) begin
            nxt_high = addr_i;
        end
    end

    // Registers only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            strobe_ff <= 1'b0;
            high_ff   <= MBSI_HIGH_RESET;
        end else begin
            strobe_ff <= nxt_strobe;
            high_ff   <= nxt_high;
        end
    end

    assign high_o = high_ff;

    // byte present during strobe survives its fall
    latch_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (strobe_ff && !strobe_i) |=> (high_ff == $past(addr_i, 2)))
        else $error("high byte not taken at strobe end");

endmodule : mbsi_addr_latch

// >>> verilog/mbsi_select.sv
// Select, chip select and inhibit logic of the memory board
`timescale 1ns/1ps
module mbsi_select
    import mbsi_pkg::*;
(
    input  wire logic        CLK_I,        // System clock, 10 MHz
    input  wire logic        SRST_I,       // Synchronous reset, bus clear
    input  wire logic        ALS_I,        // Address latch strobe
    input  wire logic        OTS_I,        // Output timing strobe
    input  wire logic [7:0]  ADDR_I,       // Multiplexed address bus
    input  wire logic        MEM_RD_N_I,   // Memory read, active low
    input  wire logic        MEM_WR_N_I,   // Memory write pulse, active low
    input  wire logic [3:0]  MODE_I,       // Static configuration mode
    input  wire logic        BANK_F_LINK_I, // Bank F link closed
    input  wire logic        BANK_E_LINK_I, // Bank E link closed
    input  wire logic        SEG_E_LINK_I, // Hole in bank E link closed
    input  wire logic        SEG_F_LINK_I, // Hole in bank F link closed
    input  wire logic [1:0]  HOLE_SEL_I,   // Hole decoder segment choice
    input  wire logic [7:0]  DATA_I,       // Data bus in
    output logic      [7:0]  DATA_O,       // Data bus out
    output logic             DATA_OE_O,    // Data bus driven
    output logic             BUF_IN_EN_O,  // Buffers accept bus data
    output logic      [15:0] CS_N_O,       // Chip selects, active low
    output logic             MEM_OE_N_O,   // Memory output enable, active low
    output logic             MEM_WE_N_O,   // Memory write enable, active low
    output logic             MEM_SEL_O,    // Memory select term
    output logic      [7:0]  WR_DATA_O,    // Data taken from bus
    input  wire logic [7:0]  RD_DATA_I     // Data from memory chips
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // One of four decoder, active low
    function automatic logic [3:0] dec4_n(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'hF;
        r[sel] = 1'b0;
        return r;
    endfunction : dec4_n

    logic [7:0] high;
    logic [7:0] data_ff;
    logic [7:0] nxt_data;
    logic [7:0] wr_ff;
    logic [7:0] nxt_wr;
    logic       data_oe_ff;
    logic       nxt_data_oe;
    logic       in_space;
    logic       small_part;
    logic [3:0] nib;
    logic [3:0] blk_n;
    logic [3:0] sub_n;
    logic [3:0] hole_n;
    logic       inh_bank;
    logic       inh_hole;
    logic [2:0] gate_in_n;
    logic       sel;
    mbsi_mode_type mode;

    // shared latch of the high byte
    mbsi_addr_latch u_latch (
        .clk_i    (CLK_I),
        .srst_i   (SRST_I),
        .strobe_i (ALS_I),
        .addr_i   (ADDR_I),
        .high_o   (high)
    );

    // ************************************************************
    // Address space placement
    // ************************************************************
    // links read combinationally, held static by the board
    assign mode = (MODE_I <= MBSI_NUM_MODES - 4'h1) ? mbsi_mode_type'(MODE_I)
                                                    : mbsi_mode_type'(MBSI_MODE_RESET);

    // fifteen modes map to part size and half, large parts to the whole space
    // unknown mode falls back to small ROM low half
    always_comb begin
        small_part = 1'b1;
        in_space   = 1'b0;
        case (mode)
            MBSI_ROM4K_FULL, MBSI_ROM4K_FULL_INH, MBSI_ROM4K_NO_F: begin
                small_part = 1'b0;
                in_space   = 1'b1;
            end
            MBSI_ROM2K_HIGH, MBSI_ROM2K_HIGH_INH, MBSI_RAM_HIGH,
            MBSI_RAM_HIGH_INH, MBSI_MIX_HIGH, MBSI_MIX_HIGH_INH: begin
                in_space = high[7];
            end
            default: begin
                in_space = !high[7];
            end
        endcase
    end

    // ************************************************************
    // Chip select decode
    // ************************************************************
    // large parts use 7:6 and 5:4, small parts shift down one
    assign nib   = small_part ? high[6:3] : high[7:4];
    assign blk_n = dec4_n(nib[3:2]);
    assign sub_n = dec4_n(nib[1:0]);

    // exactly one hole segment output active
    assign hole_n = dec4_n(HOLE_SEL_I);

    // ************************************************************
    // Inhibit terms
    // ************************************************************
    // bank F dropped when its link open
    // bank E dropped when its link open
    always_comb begin
        inh_bank = 1'b0;
        if (!small_part && !BANK_F_LINK_I && high[7:4] == MBSI_BANK_F) begin
            inh_bank = 1'b1;
        end
        if (!small_part && !BANK_E_LINK_I && high[7:4] == MBSI_BANK_E) begin
            inh_bank = 1'b1;
        end
        if (mode == MBSI_ROM4K_NO_F && high[7:4] == MBSI_BANK_F) begin
            inh_bank = 1'b1;
        end
    end

    // holes act with bank links closed
    // segment link picks bank E or F
    always_comb begin
        inh_hole = 1'b0;
        if (!small_part && !hole_n[high[MBSI_SEG_HI:MBSI_SEG_LO]]) begin
            if (SEG_E_LINK_I && high[7:4] == MBSI_BANK_E) begin
                inh_hole = 1'b1;
            end
            if (SEG_F_LINK_I && high[7:4] == MBSI_BANK_F) begin
                inh_hole = 1'b1;
            end
        end
    end

    // ************************************************************
    // Select gate and outputs
    // ************************************************************
    // select when the space input and either strobe input are low
    assign gate_in_n = {!(in_space && !inh_bank && !inh_hole), MEM_RD_N_I, MEM_WR_N_I};
    assign sel       = (gate_in_n[2] == 1'b0) && !(gate_in_n[1] && gate_in_n[0]);

    // inhibited space gives no chip select
    always_comb begin
        CS_N_O = 16'hFFFF;
        if (sel) begin
            CS_N_O[{nib[3:2], nib[1:0]}] = blk_n[nib[3:2]] | sub_n[nib[1:0]];
        end
    end

    assign MEM_SEL_O   = sel;
    // Output enable waits for the timing strobe to avoid contention
    assign MEM_OE_N_O  = !(sel && !MEM_RD_N_I && !OTS_I);
    assign MEM_WE_N_O  = !(sel && !MEM_WR_N_I);
    assign BUF_IN_EN_O = sel && MEM_RD_N_I;

    // Data registers: read data and taken write data
    always_comb begin
        nxt_data    = data_ff;
        nxt_wr      = wr_ff;
        // drive only while selected and reading
        nxt_data_oe = sel && !MEM_RD_N_I;
        if (sel && !MEM_RD_N_I) begin
            nxt_data = RD_DATA_I;
        end
        if (sel && MEM_RD_N_I) begin
            nxt_wr = DATA_I;
        end
    end

    // Registers only; bus drive lags the select by one edge
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            data_ff    <= MBSI_HIGH_RESET;
            wr_ff      <= MBSI_HIGH_RESET;
            data_oe_ff <= 1'b0;
        end else begin
            data_ff    <= nxt_data;
            wr_ff      <= nxt_wr;
            data_oe_ff <= nxt_data_oe;
        end
    end

    assign DATA_O    = data_ff;
    assign WR_DATA_O = wr_ff;
    assign DATA_OE_O = data_oe_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence rd_sel_s;
        sel && !MEM_RD_N_I;
    endsequence

    bus_drive_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        rd_sel_s |=> DATA_OE_O)
        else $error("bus not driven on selected read");
    gate_need_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        MEM_SEL_O |-> (!MEM_RD_N_I || !MEM_WR_N_I))
        else $error("select without a strobe");
    bank_f_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (!small_part && !BANK_F_LINK_I && high[7:4] == MBSI_BANK_F) |-> !sel)
        else $error("bank F answered with link open");
    bank_e_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (!small_part && !BANK_E_LINK_I && high[7:4] == MBSI_BANK_E) |-> !sel)
        else $error("bank E answered with link open");
    hole_one_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        $onehot(~hole_n))
        else $error("hole decoder not one-hot");
    hole_bank_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        inh_hole |-> (high[7:4] == MBSI_BANK_E || high[7:4] == MBSI_BANK_F))
        else $error("hole outside banks E and F");
    no_cs_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (inh_bank || inh_hole) |-> (CS_N_O == 16'hFFFF) ##1 !DATA_OE_O)
        else $error("inhibited space selected");
    cs_one_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        sel |-> (CS_N_O[nib] == 1'b0 && $countones(~CS_N_O) == 1))
        else $error("chip select decode wrong");
    low_half_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (mode == MBSI_ROM2K_LOW && high[7]) |-> !sel)
        else $error("default mode answered high half");

endmodule : mbsi_select
